// >>> design/core_regs_pkg.sv
// Constants and types shared by the core register block
package core_regs_pkg;
    // ==========================================
    // Memory layout
    localparam int unsigned DATA_W = 8;
    localparam int unsigned RAM_AW = 8;
    localparam logic [7:0] SPECIAL_BASE = 8'h80;
    localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
    localparam logic [7:0] BIT_SPECIAL_BASE = 8'h80;
    localparam int unsigned BANK_REGS = 8;

    // ==========================================
    // Special register addresses
    localparam logic [7:0] ADDR_STACK = 8'h81;
    localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
    localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
    localparam logic [7:0] ADDR_PTR_PAGE = 8'h84;
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_STATUS = 8'hd0;
    localparam logic [7:0] ADDR_ARITH = 8'he0;
    localparam logic [7:0] ADDR_HELPER = 8'hf0;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_STACK = 8'h07;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ==========================================
    // Status word fields
    localparam int unsigned ST_CARRY = 7;
    localparam int unsigned ST_AUX_CARRY = 6;
    localparam int unsigned ST_USER_ZERO = 5;
    localparam int unsigned ST_BANK_HIGH = 4;
    localparam int unsigned ST_BANK_LOW = 3;
    localparam int unsigned ST_OVERRUN = 2;
    localparam int unsigned ST_USER_ONE = 1;
    localparam int unsigned ST_PARITY = 0;

    // ==========================================
    // Power control fields
    localparam int unsigned PC_BAUD = 7;
    localparam int unsigned PC_LATCH = 4;
    localparam int unsigned PC_FLAG_ONE = 3;
    localparam int unsigned PC_FLAG_ZERO = 2;
    localparam int unsigned PC_POWER_DOWN = 1;
    localparam int unsigned PC_IDLE = 0;
    localparam logic [7:0] PC_WMASK = 8'h9f;

    // ==========================================
    // Access operations
    typedef enum logic [3:0] {
        OP_NONE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR, OP_REG_RD, OP_REG_WR,
        OP_BIT_RD, OP_BIT_WR, OP_PUSH, OP_POP, OP_INC_PTR
    } op_e;
endpackage

// >>> design/ram_port_if.sv
// Port between the register block and its internal RAM
`timescale 1ns/10ps
interface ram_port_if #(parameter int unsigned AW = 8, parameter int unsigned DW = 8);
    logic [AW-1:0] addr;
    logic we;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport user (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface // ram_port_if

// >>> design/core_ram.sv
// Internal data RAM: asynchronous read, clocked write
`timescale 1ns/10ps
module core_ram #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 8
) (
    input wire logic clk_sys,
    input wire logic ce,
    ram_port_if.mem port
);
    // ==========================================
    // Storage
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    if (AW < 7 || DW != 8) begin : g_check
        $error("core_ram needs AW >= 7 and DW == 8");
    end

    assign port.rdata = mem_q[port.addr];

    // No reset: RAM content is undefined after power-up
    always_ff @(posedge clk_sys) begin
        if (ce && port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
    end
endmodule // core_ram

// >>> design/cpu_core_status_registers.sv
// Core register set: banks, bit space, stack, data pointer, status and power control
// How it works
// - Lowest 32 RAM bytes form four banks of eight working registers.
// - Sixteen bytes above the banks are bit-addressable as bits 00h to 7fh.
// - Special registers sit in upper 128 bytes, reached by direct and bit addressing only.
// - Nonvolatile data memory is reached only through control registers in special space.
// - Push increments stack pointer first, then stores at the new address.
// - Stack pointer resets to 07h, so first entry lands at 08h.
// - Data pointer is three separate bytes: page, high and low.
// - Incrementing the 16-bit pair carries out of high byte into page.
// - Status word: carry 7, aux carry 6, flag 5, overflow 2, flag 1, parity 0.
// - Status bits 4 and 3 select the active register bank.
// - Power control at 87h, resets 00h, byte access only, bits 6:5 reserved.
// - Power bits: 7 baud double, 4 latch strobe off, 1 power-down, 0 idle.
// - Arithmetic register serves the ALU; helper register joins it for multiply and divide.
`timescale 1ns/10ps
module cpu_core_status_registers
    import core_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input wire op_e op,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic bit_in,
    input wire logic alu_arith_we,
    input wire logic [7:0] alu_arith,
    input wire logic alu_helper_we,
    input wire logic [7:0] alu_helper,
    input wire logic alu_flag_we,
    input wire logic alu_cy,
    input wire logic alu_ac,
    input wire logic alu_ov,
    input wire logic [7:0] ext_rdata,
    output logic ext_sel,
    output logic ext_we,
    output logic [7:0] ext_addr,
    output logic [7:0] ext_wdata,
    output logic done_q,
    output logic [7:0] rdata_q,
    output logic bit_out_q,
    output logic [7:0] main_arith_register,
    output logic [7:0] helper_register,
    output logic [7:0] stack_pointer,
    output logic [23:0] pointer_address,
    output logic [7:0] program_status_word,
    output logic [1:0] active_bank,
    output logic baud_doubler,
    output logic latch_strobe_disable,
    output logic power_down_enable,
    output logic sleep_enable
);
    // ==========================================
    // State
    logic [7:0] arith_q, arith_d, helper_q, helper_d, stack_q, stack_d;
    logic [7:0] ptr_low_q, ptr_low_d, ptr_high_q, ptr_high_d, ptr_page_q, ptr_page_d;
    logic [7:1] status_q, status_d;
    logic [7:0] power_q, power_d;
    logic done_d, bit_out_d;
    logic [7:0] rdata_d;
    logic parity;
    logic [7:0] status_full;
    logic [7:0] spc_addr, spc_rd, spc_wval;
    logic spc_we, spc_hit;
    logic [2:0] bit_sel;
    logic [7:0] bit_byte;

    ram_port_if #(.AW(RAM_AW), .DW(DATA_W)) ram ();

    core_ram #(.AW(RAM_AW), .DW(DATA_W)) u_ram (
        .clk_sys(clk_sys),
        .ce(ce),
        .port(ram)
    );

    assign parity = ^arith_q;
    assign status_full = {status_q, parity};

    // ==========================================
    // Special register read decode
    always_comb begin
        spc_hit = 1'b1;
        unique case (spc_addr)
            ADDR_ARITH: spc_rd = arith_q;
            ADDR_HELPER: spc_rd = helper_q;
            ADDR_STACK: spc_rd = stack_q;
            ADDR_PTR_LOW: spc_rd = ptr_low_q;
            ADDR_PTR_HIGH: spc_rd = ptr_high_q;
            ADDR_PTR_PAGE: spc_rd = ptr_page_q;
            ADDR_STATUS: spc_rd = status_full;
            ADDR_POWER: spc_rd = power_q & PC_WMASK;
            default: begin
                spc_rd = ext_rdata;
                spc_hit = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Access sequencing
    always_comb begin
        arith_d = arith_q;
        helper_d = helper_q;
        stack_d = stack_q;
        ptr_low_d = ptr_low_q;
        ptr_high_d = ptr_high_q;
        ptr_page_d = ptr_page_q;
        status_d = status_q;
        power_d = power_q;
        rdata_d = rdata_q;
        bit_out_d = bit_out_q;
        done_d = 1'b0;
        ram.addr = addr;
        ram.we = 1'b0;
        ram.wdata = wdata;
        spc_addr = addr;
        spc_we = 1'b0;
        spc_wval = wdata;
        bit_sel = addr[2:0];
        bit_byte = 8'h00;
        // ALU results land first; a same-cycle special register write overrides them
        // arithmetic, helper and flag updates
        if (alu_arith_we) begin
            arith_d = alu_arith;
        end
        if (alu_helper_we) begin
            helper_d = alu_helper;
        end
        if (alu_flag_we) begin
            status_d[ST_CARRY] = alu_cy;
            status_d[ST_AUX_CARRY] = alu_ac;
            status_d[ST_OVERRUN] = alu_ov;
        end
        unique case (op)
            OP_NONE: ;
            OP_DIR_RD, OP_DIR_WR: begin
                done_d = 1'b1;
                if (addr >= SPECIAL_BASE) begin
                    spc_we = (op == OP_DIR_WR);
                    rdata_d = spc_rd;
                end else begin
                    ram.we = (op == OP_DIR_WR);
                    rdata_d = ram.rdata;
                end
            end
            OP_IND_RD, OP_IND_WR: begin
                done_d = 1'b1;
                ram.we = (op == OP_IND_WR);
                rdata_d = ram.rdata;
            end
            OP_REG_RD, OP_REG_WR: begin
                done_d = 1'b1;
                ram.addr = {3'b000, status_q[ST_BANK_HIGH], status_q[ST_BANK_LOW], addr[2:0]};
                ram.we = (op == OP_REG_WR);
                rdata_d = ram.rdata;
            end
            OP_BIT_RD, OP_BIT_WR: begin
                done_d = 1'b1;
                if (addr < BIT_SPECIAL_BASE) begin
                    ram.addr = BIT_BYTE_BASE + {4'h0, addr[6:3]};
                    bit_byte = ram.rdata;
                end else begin
                    // Only addresses ending in 0h or 8h hold bits
                    spc_addr = {addr[7:3], 3'b000};
                    bit_byte = spc_rd;
                end
                bit_out_d = bit_byte[bit_sel];
                ram.wdata = bit_byte;
                ram.wdata[bit_sel] = bit_in;
                spc_wval = ram.wdata;
                ram.we = (op == OP_BIT_WR) && (addr < BIT_SPECIAL_BASE);
                spc_we = (op == OP_BIT_WR) && (addr >= BIT_SPECIAL_BASE);
            end
            OP_PUSH: begin
                done_d = 1'b1;
                stack_d = stack_q + 8'h01;
                ram.addr = stack_q + 8'h01;
                ram.we = 1'b1;
            end
            // Pop reads at the pointer, then steps it down
            OP_POP: begin
                done_d = 1'b1;
                ram.addr = stack_q;
                rdata_d = ram.rdata;
                stack_d = stack_q - 8'h01;
            end
            OP_INC_PTR: begin
                done_d = 1'b1;
                {ptr_page_d, ptr_high_d, ptr_low_d} = {ptr_page_q, ptr_high_q, ptr_low_q} + 24'h000001;
            end
            default: ;
        endcase
        if (spc_we) begin
            unique case (spc_addr)
                ADDR_ARITH: arith_d = spc_wval;
                ADDR_HELPER: helper_d = spc_wval;
                ADDR_STACK: stack_d = spc_wval;
                ADDR_PTR_LOW: ptr_low_d = spc_wval;
                ADDR_PTR_HIGH: ptr_high_d = spc_wval;
                ADDR_PTR_PAGE: ptr_page_d = spc_wval;
                // Parity is derived, so the written bit 0 is dropped
                ADDR_STATUS: status_d = spc_wval[7:1];
                ADDR_POWER: power_d = spc_wval & PC_WMASK;
                default: ;
            endcase
        end
    end

    // nonvolatile controller and other peripherals on the external port
    // Bit ops on outside registers select the port too, reads included
    assign ext_sel = !spc_hit && ((((op == OP_DIR_RD) || (op == OP_DIR_WR)) && (addr >= SPECIAL_BASE))
        || (((op == OP_BIT_RD) || (op == OP_BIT_WR)) && (addr >= BIT_SPECIAL_BASE)));
    assign ext_we = ext_sel && spc_we;
    assign ext_addr = spc_addr;
    assign ext_wdata = spc_wval;

    // ==========================================
    // Registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arith_q <= RST_BYTE;
            helper_q <= RST_BYTE;
            stack_q <= RST_STACK;
            ptr_low_q <= RST_BYTE;
            ptr_high_q <= RST_BYTE;
            ptr_page_q <= RST_BYTE;
            status_q <= RST_STATUS[7:1];
            power_q <= RST_POWER;
            rdata_q <= RST_BYTE;
            bit_out_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            arith_q <= arith_d;
            helper_q <= helper_d;
            stack_q <= stack_d;
            ptr_low_q <= ptr_low_d;
            ptr_high_q <= ptr_high_d;
            ptr_page_q <= ptr_page_d;
            status_q <= status_d;
            power_q <= power_d;
            rdata_q <= rdata_d;
            bit_out_q <= bit_out_d;
            done_q <= done_d;
        end
    end

    // ==========================================
    // Outputs
    assign main_arith_register = arith_q;
    assign helper_register = helper_q;
    assign stack_pointer = stack_q;
    assign pointer_address = {ptr_page_q, ptr_high_q, ptr_low_q};
    assign program_status_word = status_full;
    assign active_bank = {status_q[ST_BANK_HIGH], status_q[ST_BANK_LOW]};
    assign baud_doubler = power_q[PC_BAUD];
    assign latch_strobe_disable = power_q[PC_LATCH];
    assign power_down_enable = power_q[PC_POWER_DOWN];
    assign sleep_enable = power_q[PC_IDLE];
endmodule // cpu_core_status_registers

// >>> sim/core_regs_sva.sv
// Port assertions for the core register block
`timescale 1ns/10ps
module core_regs_sva
    import core_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input wire op_e op,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ext_sel,
    input wire logic done_q,
    input wire logic [7:0] main_arith_register,
    input wire logic [7:0] stack_pointer,
    input wire logic [23:0] pointer_address,
    input wire logic [7:0] program_status_word,
    input wire logic [1:0] active_bank,
    input wire logic baud_doubler,
    input wire logic latch_strobe_disable,
    input wire logic power_down_enable,
    input wire logic sleep_enable
);
    // ====================
    // Helpers
    logic [7:0] wdata_q;
    always_ff @(posedge clk_sys) begin
        wdata_q <= wdata;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_taken(op_e o);
        ce && op == o;
    endsequence
    sequence s_dir_wr(logic [7:0] a);
        ce && op == OP_DIR_WR && addr == a;
    endsequence
    // ====================
    // Checks
    a_parity_tracks_arith:
        assert property (program_status_word[0] == ^main_arith_register) else $error("Parity bit wrong");
    a_bank_from_status:
        assert property (active_bank == program_status_word[4:3]) else $error("Bank select wrong");
    a_push_inc_first:
        assert property (s_taken(OP_PUSH) |=> stack_pointer == $past(stack_pointer) + 8'h01) else $error("Push");
    a_ptr_carry_page:
        assert property (s_taken(OP_INC_PTR) |=> pointer_address == $past(pointer_address) + 24'h1) else $error("Ptr");
    a_stack_reset_value:
        assert property ($rose(reset_n) |-> stack_pointer == 8'h07) else $error("Stack reset value");
    a_done_one_cycle:
        assert property (ce |=> done_q == $past(op != OP_NONE)) else $error("Done pulse wrong");
    a_power_bits_map:
        assert property (s_dir_wr(ADDR_POWER) |=> {baud_doubler, latch_strobe_disable, power_down_enable,
            sleep_enable} == {wdata_q[7], wdata_q[4], wdata_q[1:0]}) else $error("Power bits wrong");
    a_status_write:
        assert property (s_dir_wr(ADDR_STATUS) |=> program_status_word[7:1] == wdata_q[7:1]) else $error("Status");
    a_indirect_not_sfr:
        assert property (ce && (op == OP_IND_RD || op == OP_IND_WR) |-> !ext_sel) else $error("Indirect hit sfr");
endmodule // core_regs_sva

// >>> sim/testbench.sv
// Self-checking bench for the core register block
`timescale 1ns/10ps
module testbench import core_regs_pkg::*; ;
    logic clk_sys = 1'b0, reset_n = 1'b0, ce = 1'b1, bit_in = 1'b0;
    op_e op = OP_NONE;
    logic [7:0] addr = 8'h00, wdata = 8'h00, alu_arith = 8'h00, alu_helper = 8'h00, ext_rdata = 8'h00;
    logic alu_arith_we = 1'b0, alu_helper_we = 1'b0, alu_flag_we = 1'b0, alu_cy = 1'b0, alu_ac = 1'b0, alu_ov = 1'b0;
    logic ext_sel, ext_we, done_q, bit_out_q, baud_doubler, latch_strobe_disable, power_down_enable, sleep_enable;
    logic [7:0] ext_addr, ext_wdata, rdata_q, main_arith_register, helper_register, stack_pointer;
    logic [7:0] program_status_word;
    logic [23:0] pointer_address;
    logic [1:0] active_bank;
    logic [17:0] ext_seen;
    int compares = 0, miscompares = 0;
    cpu_core_status_registers u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .op(op), .addr(addr), .wdata(wdata), .bit_in(bit_in),
        .alu_arith_we(alu_arith_we), .alu_arith(alu_arith), .alu_helper_we(alu_helper_we),
        .alu_helper(alu_helper), .alu_flag_we(alu_flag_we), .alu_cy(alu_cy), .alu_ac(alu_ac), .alu_ov(alu_ov),
        .ext_rdata(ext_rdata), .ext_sel(ext_sel), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .done_q(done_q), .rdata_q(rdata_q), .bit_out_q(bit_out_q), .main_arith_register(main_arith_register),
        .helper_register(helper_register), .stack_pointer(stack_pointer), .pointer_address(pointer_address),
        .program_status_word(program_status_word), .active_bank(active_bank), .baud_doubler(baud_doubler),
        .latch_strobe_disable(latch_strobe_disable), .power_down_enable(power_down_enable),
        .sleep_enable(sleep_enable)
    );
    always #20 clk_sys = ~clk_sys;
    // ====================
    // Tasks
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Inputs change on falling edges only, one op per cycle
    task automatic run(input op_e o, input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0);
        op = o;
        addr = a;
        wdata = d;
        bit_in = b;
        #1 ext_seen = {ext_sel, ext_we, ext_addr, ext_wdata};
        @(negedge clk_sys);
        check("done", 24'(done_q), 24'(o != OP_NONE));
    endtask
    function automatic logic [7:0] bit_byte(input logic [6:0] b);
        return 8'h20 + 8'(b[6:3]);
    endfunction
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end
    // ====================
    // Scenarios
    initial begin
        logic [7:0] d, r;
        logic [6:0] ba;
        void'($urandom(32'hc072));
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        check("stack", 24'(stack_pointer), 24'h07);
        check("pwr", 24'({baud_doubler, latch_strobe_disable, power_down_enable, sleep_enable}), 24'h0);
        for (int b = 0; b < 4; b++) begin
            d = 8'($urandom);
            r = 8'($urandom_range(7));
            run(OP_DIR_WR, ADDR_STATUS, 8'(b << 3));
            check("bank", 24'(active_bank), 24'(b));
            run(OP_REG_WR, r, d);
            run(OP_IND_RD, 8'(b * 8) + r, 8'h00);
            check("bank ram", 24'(rdata_q), 24'(d));
            run(OP_REG_RD, r, 8'h00);
            check("bank reg rd", 24'(rdata_q), 24'(d));
        end
        // Status now selects bank 3; clearing bit d4h must leave bank 1
        run(OP_BIT_WR, 8'hd4, 8'h00, 1'b0);
        check("bank bit", 24'({active_bank, bit_out_q}), 24'h3);
        // Both ends of the bit space first
        for (int i = 0; i < 6; i++) begin
            ba = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
            run(OP_IND_WR, bit_byte(ba), 8'h00);
            run(OP_BIT_WR, {1'b0, ba}, 8'h00, 1'b1);
            check("bit old", 24'(bit_out_q), 24'h0);
            run(OP_BIT_RD, {1'b0, ba}, 8'h00);
            check("bit new", 24'(bit_out_q), 24'h1);
            run(OP_IND_RD, bit_byte(ba), 8'h00);
            check("bit", 24'(rdata_q), 24'(8'h01 << ba[2:0]));
        end
        d = 8'($urandom);
        r = ~d;
        run(OP_DIR_WR, ADDR_HELPER, d);
        run(OP_IND_WR, ADDR_HELPER, r);
        run(OP_DIR_RD, ADDR_HELPER, 8'h00);
        check("sfr dir", 24'(rdata_q), 24'(d));
        run(OP_IND_RD, ADDR_HELPER, 8'h00);
        check("sfr ind", 24'(rdata_q), 24'(r));
        ext_rdata = 8'($urandom);
        run(OP_DIR_WR, 8'hb9, d);
        check("ext wr", 24'(ext_seen), {8'h03, 8'hb9, d});
        run(OP_DIR_RD, 8'hb9, 8'h00);
        check("ext rd", 24'(rdata_q), 24'(ext_rdata));
        check("ext rd sel", 24'(ext_seen[17:16]), 24'h2);
        run(OP_PUSH, 8'h00, d);
        check("stack push", 24'(stack_pointer), 24'h08);
        run(OP_IND_RD, 8'h08, 8'h00);
        check("stack ram", 24'(rdata_q), 24'(d));
        run(OP_POP, 8'h00, 8'h00);
        check("pop", 24'({stack_pointer, rdata_q}), {8'h00, 8'h07, d});
        // Clock enable low: a push must neither move the pointer nor write RAM
        run(OP_NONE, 8'h00, 8'h00);
        ce = 1'b0;
        op = OP_PUSH;
        wdata = ~d;
        repeat (2) @(negedge clk_sys);
        check("frozen", 24'({done_q, stack_pointer}), 24'h007);
        ce = 1'b1;
        run(OP_IND_RD, 8'h08, 8'h00);
        check("frozen ram", 24'(rdata_q), 24'(d));
        run(OP_DIR_WR, ADDR_PTR_PAGE, 8'h12);
        run(OP_DIR_WR, ADDR_PTR_HIGH, 8'hff);
        run(OP_DIR_WR, ADDR_PTR_LOW, 8'hff);
        check("ptr", pointer_address, 24'h12ffff);
        run(OP_INC_PTR, 8'h00, 8'h00);
        run(OP_DIR_RD, ADDR_PTR_PAGE, 8'h00);
        check("ptr inc", {rdata_q, pointer_address[15:0]}, 24'h130000);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            r = 8'($urandom);
            {alu_arith_we, alu_helper_we, alu_flag_we} = 3'b111;
            alu_arith = d;
            alu_helper = r;
            {alu_cy, alu_ac, alu_ov} = 3'(i);
            run(OP_NONE, 8'h00, 8'h00);
            {alu_arith_we, alu_helper_we, alu_flag_we} = 3'b000;
            check("alu", 24'({main_arith_register, helper_register}), {8'h00, d, r});
            check("flags", 24'({program_status_word[7:6], program_status_word[2]}), 24'(i));
            check("parity", 24'(program_status_word[0]), 24'(^d));
            run(OP_DIR_WR, ADDR_STATUS, r);
            run(OP_DIR_RD, ADDR_STATUS, 8'h00);
            check("status rd", 24'(rdata_q), {16'h0000, r[7:1], ^d});
            run(OP_DIR_WR, ADDR_POWER, r);
            run(OP_DIR_RD, ADDR_POWER, 8'h00);
            check("pwr rd", 24'(rdata_q), {16'h0000, r[7], 2'b00, r[4:0]});
            check("pwr bits", 24'({baud_doubler, latch_strobe_disable, power_down_enable, sleep_enable}),
                24'({r[7], r[4], r[1:0]}));
        end
        // Reset again mid-run: stack, pointer, status and power back to their reset values
        reset_n = 1'b0;
        @(negedge clk_sys);
        reset_n = 1'b1;
        check("stack rst", 24'(stack_pointer), 24'h07);
        check("ptr rst", pointer_address, 24'h000000);
        check("status rst", 24'(program_status_word), 24'h00);
        run(OP_DIR_RD, ADDR_POWER, 8'h00);
        check("pwr rst", 24'(rdata_q), 24'h00);
        wrap_up();
    end
endmodule // testbench
bind cpu_core_status_registers core_regs_sva u_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .op(op), .addr(addr), .wdata(wdata), .ext_sel(ext_sel),
    .done_q(done_q), .main_arith_register(main_arith_register), .stack_pointer(stack_pointer),
    .pointer_address(pointer_address), .program_status_word(program_status_word), .active_bank(active_bank),
    .baud_doubler(baud_doubler), .latch_strobe_disable(latch_strobe_disable),
    .power_down_enable(power_down_enable), .sleep_enable(sleep_enable)
);
